// File: rtl/card_bus_host_controller.sv
// Functional notes
// - data packets: stream or block, start/end bits
// - block packets carry CRC16 CCITT, streams none
// - eight card clocks before clock stops
// - clock may stop on busy; give edges later
// - card clock divides system clock; zero stops
// - enable bit runs controller and card clock
// - divider rewrite takes effect on the fly
// - five bytes loaded; start bit pulse sends
// - sample response settings before sending command
// - lock command FIFO while sending command
// - end of command sets done flag
// - pointer reset pulse discards partial command
// - response done flag, format and CRC status
// - clear response status on send, update after
// - pointer reset pulse restarts response reading
// - path reset pulse returns command path idle
// - one 16-byte FIFO shared by both directions
// - command token 48 bits, MSB first
module card_bus_host_controller (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     cardCmdIn,
  input  wire logic                     cardDataIn,
  output card_bus_pkg::card_pins_s      cardPins
);
  import card_bus_pkg::*;

  function automatic logic [6:0] crc7Step(input logic [6:0] c, input logic b);
    return {c[5:0], 1'b0} ^ ((b ^ c[6]) ? CRC7_POLY : 7'h00);
  endfunction

  function automatic logic [15:0] crc16Step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((b ^ c[15]) ? CRC16_POLY : 16'h0000);
  endfunction

  function automatic logic [6:0] crc7Of(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = crc7Step(c, d[i]);
    end
    return c;
  endfunction

  logic [7:0]  ctl0, ctl1, ctl2, clkDiv;
  logic        awHeld, wHeld, wStrb0;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic        cmdGo, cmdWptrClr, respRptrClr, cmdPathClr, dataGo, dataPathClr;
  logic        flagCmdDone, flagRespDone, flagDataDone;
  logic        evtCmdDone, evtRespDone, evtDataDone;
  logic        cmdLock, respFmtOk, respCrcOk, dataFmtOk, dataCrcOk;
  logic [7:0]  cmdFifo [CMD_BYTES];
  logic [2:0]  cmdWptr;
  logic [4:0]  respRptr;
  logic [135:0] respBuf, respShift, respSlide;
  logic [47:0] cmdShift;
  logic [7:0]  bitCnt, respLen;
  logic [6:0]  rxCrc7;
  logic        transBit;
  cmd_setup_s  setup;
  cmd_state_e  cmdState;
  logic [7:0]  dataMem [DATA_DEPTH];
  logic [4:0]  fWptr, fRptr, fCount;
  logic [7:0]  fifoHead, rxByte, byteShift, rdMux;
  logic        rxPush, busPush, busPop, txPop, loadNow, lastByte, needByte;
  data_state_e dState;
  data_phase_e dPhase;
  logic [3:0]  bitIdx, tail;
  logic [11:0] byteCnt, blkLen;
  logic [15:0] crc16, crcNext;
  logic        dOut, cardClk, edgeDue, rise, run, dataStall, cardBusy, active, prevActive;
  logic [7:0]  halfCnt;

  wire writeNow = awHeld && wHeld && !s_axi_bvalid;
  wire readNow  = s_axi_arvalid && s_axi_arready;
  wire dirTx    = ctl1[B_DATA_TX];
  wire fEmpty   = (fCount == 5'h00);
  wire fFull    = (fCount == DATA_DEPTH);
  wire wrCtl0   = writeNow && wStrb0 && (awAddr == OFF_CTL0);
  wire wrCtl1   = writeNow && wStrb0 && (awAddr == OFF_CTL1);
  wire wrCtl2   = writeNow && wStrb0 && (awAddr == OFF_CTL2);

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_CLK_DIV);
  endfunction

  // bus handshake: address and data are latched independently, either order
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0;
      wStrb0       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (writeNow) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld  <= 1'b1;
        wData  <= s_axi_wdata;
        wStrb0 <= s_axi_wstrb[0];
      end else if (writeNow) begin
        wHeld <= 1'b0;
      end
      if (writeNow) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; actions fire on the clearing write of a set bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl0 <= CTL_RESET;
      ctl1 <= CTL_RESET;
      ctl2 <= CTL_RESET;
      clkDiv <= DIV_RESET;
      {cmdGo, cmdWptrClr, respRptrClr, cmdPathClr, dataGo, dataPathClr} <= 6'h00;
    end else begin
      cmdWptrClr  <= wrCtl0 && ctl0[B_CMD_WPTR_RESET] && !wData[B_CMD_WPTR_RESET];
      respRptrClr <= wrCtl0 && ctl0[B_RESP_RPTR_RESET] && !wData[B_RESP_RPTR_RESET];
      cmdGo       <= wrCtl1 && ctl1[B_CMD_START] && !wData[B_CMD_START];
      dataGo      <= wrCtl1 && ctl1[B_DATA_START] && !wData[B_DATA_START];
      cmdPathClr  <= wrCtl2 && ctl2[B_CMD_PATH_RESET] && !wData[B_CMD_PATH_RESET];
      dataPathClr <= wrCtl2 && ctl2[B_DATA_PATH_RESET] && !wData[B_DATA_PATH_RESET];
      if (wrCtl0) ctl0 <= wData[7:0];
      if (wrCtl1) ctl1 <= wData[7:0];
      if (wrCtl2) ctl2 <= wData[7:0];
      if (writeNow && wStrb0 && awAddr == OFF_CLK_DIV) clkDiv <= wData[7:0];
    end
  end

  // sticky event flags, cleared by reading them; a new event wins
  wire flagsRead = readNow && (s_axi_araddr == OFF_FLAGS);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {flagCmdDone, flagRespDone, flagDataDone} <= 3'h0;
    end else begin
      flagCmdDone  <= (flagCmdDone && !flagsRead) || evtCmdDone;
      flagRespDone <= (flagRespDone && !flagsRead) || evtRespDone;
      flagDataDone <= (flagDataDone && !flagsRead) || evtDataDone;
    end
  end

  // card clock: period is 2*divider system clocks, only stopped while low
  assign active    = (cmdState != CMD_IDLE) || (dState != D_IDLE);
  assign cardBusy  = !cardDataIn && (dState == D_IDLE);
  assign run       = ctl2[B_CTRL_ENABLE] && !dataStall
                     && (active || tail != 4'h0 || cardBusy);
  assign edgeDue   = (clkDiv != 8'h00) && ctl2[B_CTRL_ENABLE] && (run || cardClk)
                     && (halfCnt + 8'h01 >= clkDiv);
  assign rise      = edgeDue && !cardClk;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || clkDiv == 8'h00 || !ctl2[B_CTRL_ENABLE]) begin
      cardClk <= 1'b0;
      halfCnt <= 8'h00;
    end else if (edgeDue) begin
      cardClk <= !cardClk;
      halfCnt <= 8'h00;
    end else if (run || cardClk) begin
      halfCnt <= halfCnt + 8'h01;
    end else begin
      halfCnt <= 8'h00;
    end
  end

  // trailing clocks once the command and data paths are both idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tail       <= 4'h0;
      prevActive <= 1'b0;
    end else begin
      prevActive <= active;
      if (prevActive && !active) tail <= TAIL_CLOCKS;
      else if (rise && tail != 4'h0) tail <= tail - 4'h1;
    end
  end

  // command byte store, locked while a command is on the line
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmdWptrClr || (cmdGo && cmdState == CMD_IDLE)) begin
      cmdWptr <= 3'h0;
    end else if (writeNow && wStrb0 && awAddr == OFF_CMD_PORT && !cmdLock && cmdWptr < CMD_BYTES) begin
      cmdFifo[cmdWptr] <= wData[7:0];
      cmdWptr <= cmdWptr + 3'h1;
    end
  end

  wire [39:0] cmdFrame = {2'b01, cmdFifo[0][5:0], cmdFifo[1], cmdFifo[2], cmdFifo[3], cmdFifo[4]};
  wire        crc7En   = setup.respLong ? (bitCnt >= 8'h08 && bitCnt < 8'h80) : (bitCnt < 8'h28);

  always_ff @(posedge sys_clk) begin
    evtCmdDone  <= 1'b0;
    evtRespDone <= 1'b0;
    if (sys_rst || cmdPathClr) begin
      cmdState  <= CMD_IDLE;
      cmdLock   <= 1'b0;
      cmdShift  <= '1;
      bitCnt    <= 8'h00;
      respLen   <= RESP_SHORT;
      setup     <= '0;
      respFmtOk <= 1'b0;
      respCrcOk <= 1'b0;
      rxCrc7    <= 7'h00;
      transBit  <= 1'b0;
      respShift <= '0;
      respBuf   <= '0;
    end else begin
      case (cmdState)
        CMD_IDLE: if (cmdGo) begin
          setup     <= '{ctl1[B_RESP_EXPECTED], ctl0[B_RESP_SIZE_LONG], ctl0[B_RESP_CRC_OFF]};
          respLen   <= ctl0[B_RESP_SIZE_LONG] ? RESP_LONG : RESP_SHORT;
          cmdShift  <= {cmdFrame, crc7Of(cmdFrame), 1'b1};
          bitCnt    <= 8'h00;
          cmdLock   <= 1'b1;
          respFmtOk <= 1'b0;
          respCrcOk <= 1'b0;
          cmdState  <= CMD_SEND;
        end
        CMD_SEND: if (rise) begin
          cmdShift <= {cmdShift[46:0], 1'b1};
          bitCnt   <= bitCnt + 8'h01;
          if (bitCnt == CMD_BITS - 8'h01) begin
            cmdLock    <= 1'b0;
            evtCmdDone <= 1'b1;
            cmdState   <= setup.respExpected ? CMD_WAIT : CMD_IDLE;
          end
        end
        CMD_WAIT: if (rise && !cardCmdIn) begin
          respShift <= '0;
          rxCrc7    <= 7'h00;
          bitCnt    <= 8'h01;
          cmdState  <= CMD_RECV;
        end
        CMD_RECV: if (rise) begin
          respShift <= {respShift[134:0], cardCmdIn};
          bitCnt    <= bitCnt + 8'h01;
          if (crc7En) rxCrc7 <= crc7Step(rxCrc7, cardCmdIn);
          if (bitCnt == 8'h01) transBit <= cardCmdIn;
          if (bitCnt == respLen - 8'h01) begin
            respFmtOk   <= cardCmdIn && !transBit;
            respCrcOk   <= setup.crcOff || (rxCrc7 == respShift[6:0]);
            respBuf     <= setup.respLong ? {respShift[134:0], cardCmdIn}
                                          : {respShift[46:0], cardCmdIn, 88'h0};
            evtRespDone <= 1'b1;
            cmdState    <= CMD_IDLE;
          end
        end
        default: cmdState <= CMD_IDLE;
      endcase
    end
  end

  // response bytes are read MSB first through the command port
  assign respSlide = respBuf << {respRptr, 3'b000};
  always_ff @(posedge sys_clk) begin
    if (sys_rst || respRptrClr || evtRespDone) begin
      respRptr <= 5'h00;
    end else if (readNow && s_axi_araddr == OFF_CMD_PORT && respRptr < RESP_BYTES) begin
      respRptr <= respRptr + 5'h01;
    end
  end

  // one 16-byte store serves whichever direction is selected
  assign fCount   = fWptr - fRptr;
  assign fifoHead = dataMem[fRptr[3:0]];
  assign busPush  = writeNow && wStrb0 && awAddr == OFF_DATA_PORT && dirTx && !fFull;
  assign busPop   = readNow && s_axi_araddr == OFF_DATA_PORT && !dirTx && !fEmpty;

  always_ff @(posedge sys_clk) begin
    if (busPush) dataMem[fWptr[3:0]] <= wData[7:0];
    else if (rxPush) dataMem[fWptr[3:0]] <= rxByte;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || dataPathClr) begin
      fWptr <= 5'h00;
      fRptr <= 5'h00;
    end else begin
      if (busPush || rxPush) fWptr <= fWptr + 5'h01;
      if (busPop || txPop) fRptr <= fRptr + 5'h01;
    end
  end

  // data packets; the card clock halts instead of overrunning or under-running, save mid-stream, where an empty FIFO ends the packet
  assign blkLen    = 12'h001 << ctl1[B_BLEN_LSB +: 4];
  assign lastByte  = ctl0[B_DATA_BLOCK] && (byteCnt + 12'h001 == blkLen);
  assign needByte  = dState == D_TX && (dPhase == P_START || (dPhase == P_DATA && bitIdx == 4'h0 && !lastByte));
  assign loadNow   = needByte && !fEmpty;
  assign txPop     = rise && loadNow;
  assign crcNext   = crc16Step(crc16, dOut);
  assign dataStall = (needByte && fEmpty && (ctl0[B_DATA_BLOCK] || dPhase == P_START))
                     || (dState == D_RX && fFull);

  always_ff @(posedge sys_clk) begin
    rxPush      <= 1'b0;
    evtDataDone <= 1'b0;
    if (sys_rst || dataPathClr) begin
      dState    <= D_IDLE;
      dPhase    <= P_START;
      dOut      <= 1'b1;
      bitIdx    <= 4'h0;
      byteCnt   <= 12'h000;
      byteShift <= 8'h00;
      rxByte    <= 8'h00;
      crc16     <= 16'h0000;
      dataFmtOk <= 1'b0;
      dataCrcOk <= 1'b0;
    end else begin
      case (dState)
        D_IDLE: if (dataGo) begin
          dState    <= dirTx ? D_TX : D_RX_WAIT;
          dPhase    <= P_START;
          dOut      <= !dirTx;
          byteCnt   <= 12'h000;
          crc16     <= 16'h0000;
          dataFmtOk <= 1'b0;
          dataCrcOk <= 1'b0;
        end
        D_TX: if (rise) begin
          if (loadNow) begin
            byteShift <= fifoHead;
            dOut      <= fifoHead[7];
            bitIdx    <= 4'h7;
            dPhase    <= P_DATA;
          end
          case (dPhase)
            P_DATA: begin
              if (bitIdx != 4'h0) begin
                byteShift <= {byteShift[6:0], 1'b0};
                dOut      <= byteShift[6];
                bitIdx    <= bitIdx - 4'h1;
                crc16     <= crcNext;
              end else begin
                byteCnt <= byteCnt + 12'h001;
                crc16   <= crcNext;
                if (lastByte) begin
                  dPhase <= P_CRC;
                  dOut   <= crcNext[15];
                  crc16  <= {crcNext[14:0], 1'b0};
                  bitIdx <= 4'hf;
                end else if (fEmpty) begin
                  dPhase <= P_END;
                  dOut   <= 1'b1;
                end
              end
            end
            P_CRC: begin
              dOut   <= (bitIdx != 4'h0) ? crc16[15] : 1'b1;
              crc16  <= {crc16[14:0], 1'b0};
              bitIdx <= bitIdx - 4'h1;
              if (bitIdx == 4'h0) dPhase <= P_END;
            end
            P_END: begin
              dState      <= D_IDLE;
              dataFmtOk   <= 1'b1;
              evtDataDone <= 1'b1;
            end
            default: ;
          endcase
        end
        D_RX_WAIT: if (rise && !cardDataIn) begin
          dState <= D_RX;
          dPhase <= P_DATA;
          bitIdx <= 4'h7;
        end
        D_RX: if (rise) begin
          crc16  <= crc16Step(crc16, cardDataIn);
          bitIdx <= bitIdx - 4'h1;
          case (dPhase)
            P_DATA: begin
              byteShift <= {byteShift[6:0], cardDataIn};
              if (bitIdx == 4'h0) begin
                rxByte  <= {byteShift[6:0], cardDataIn};
                rxPush  <= 1'b1;
                byteCnt <= byteCnt + 12'h001;
                bitIdx  <= lastByte ? 4'hf : 4'h7;
                if (lastByte) dPhase <= P_CRC;
              end
            end
            P_CRC: if (bitIdx == 4'h0) dPhase <= P_END;
            default: begin
              dataFmtOk   <= cardDataIn;
              dataCrcOk   <= (crc16 == 16'h0000);
              evtDataDone <= 1'b1;
              dState      <= D_IDLE;
            end
          endcase
        end
        default: dState <= D_IDLE;
      endcase
    end
  end

  always_comb begin
    case (s_axi_araddr)
      OFF_CTL0:      rdMux = ctl0;
      OFF_CTL1:      rdMux = ctl1;
      OFF_CTL2:      rdMux = ctl2;
      OFF_STATUS:    rdMux = {2'b00, cardBusy, dataCrcOk, dataFmtOk, respCrcOk, respFmtOk, cmdLock};
      OFF_FLAGS:     rdMux = {5'h00, flagDataDone, flagRespDone, flagCmdDone};
      OFF_CMD_PORT:  rdMux = respSlide[135:128];
      OFF_DATA_PORT: rdMux = (!dirTx && !fEmpty) ? fifoHead : 8'h00;
      OFF_CLK_DIV:   rdMux = clkDiv;
      default:       rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (readNow) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rdMux};
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign cardPins = '{clk: cardClk, cmdOut: cmdShift[47], cmdOutEnN: (cmdState != CMD_SEND),
                      dataOut: dOut, dataOutEnN: (dState != D_TX)};
endmodule // card_bus_host_controller

// File: rtl/card_bus_pkg.sv
package card_bus_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTL0      = 8'h00;
  localparam logic [7:0] OFF_CTL1      = 8'h04;
  localparam logic [7:0] OFF_CTL2      = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_FLAGS     = 8'h10;
  localparam logic [7:0] OFF_CMD_PORT  = 8'h14;
  localparam logic [7:0] OFF_DATA_PORT = 8'h18;
  localparam logic [7:0] OFF_CLK_DIV   = 8'h1c;

  // card_control_0 fields
  localparam int B_CMD_WPTR_RESET  = 0;
  localparam int B_RESP_RPTR_RESET = 1;
  localparam int B_RESP_SIZE_LONG  = 2;
  localparam int B_RESP_CRC_OFF    = 3;
  localparam int B_DATA_BLOCK      = 4;
  // card_control_1 fields
  localparam int B_CMD_START       = 0;
  localparam int B_RESP_EXPECTED   = 1;
  localparam int B_DATA_START      = 2;
  localparam int B_DATA_TX         = 3;
  localparam int B_BLEN_LSB        = 4;
  // card_control_2 fields
  localparam int B_CTRL_ENABLE     = 0;
  localparam int B_CMD_PATH_RESET  = 1;
  localparam int B_DATA_PATH_RESET = 2;

  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [7:0]  DIV_RESET      = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [6:0]  CRC7_POLY      = 7'h09;
  localparam logic [15:0] CRC16_POLY     = 16'h1021;
  localparam logic [3:0]  TAIL_CLOCKS    = 4'h8;
  localparam logic [7:0]  CMD_BITS       = 8'h30;
  localparam logic [7:0]  RESP_SHORT     = 8'h30;
  localparam logic [7:0]  RESP_LONG      = 8'h88;
  localparam logic [2:0]  CMD_BYTES      = 3'h5;
  localparam logic [4:0]  RESP_BYTES     = 5'h11;
  localparam logic [4:0]  DATA_DEPTH     = 5'h10;

  typedef enum {CMD_IDLE, CMD_SEND, CMD_WAIT, CMD_RECV} cmd_state_e;
  typedef enum {D_IDLE, D_TX, D_RX_WAIT, D_RX} data_state_e;
  typedef enum {P_START, P_DATA, P_CRC, P_END} data_phase_e;

  typedef struct packed {
    logic respExpected;
    logic respLong;
    logic crcOff;
  } cmd_setup_s;

  typedef struct packed {
    logic clk;
    logic cmdOut;
    logic cmdOutEnN;
    logic dataOut;
    logic dataOutEnN;
  } card_pins_s;
endpackage

// File: verif/card_bus_host_controller_monitor.sv
module card_bus_monitor (
  input logic                     sys_clk,
  input logic                     sys_rst,
  input logic [7:0]               s_axi_araddr,
  input logic                     s_axi_arvalid,
  input logic                     s_axi_arready,
  input logic [31:0]              s_axi_rdata,
  input logic [1:0]               s_axi_rresp,
  input logic                     s_axi_rvalid,
  input logic                     s_axi_rready,
  input logic                     s_axi_bvalid,
  input logic                     s_axi_bready,
  input card_bus_pkg::card_pins_s cardPins
);
  timeunit 1ns;
  timeprecision 1ns;
  import card_bus_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] bitCnt;
  // long response waits wrap it, harmless outside a frame
  always_ff @(posedge sys_clk)
    if (sys_rst || $fell(cardPins.cmdOutEnN)) bitCnt <= 8'h00;
    else if ($rose(cardPins.clk)) bitCnt <= bitCnt + 8'h01;
  frame_len_a: assert property ($rose(cardPins.cmdOutEnN) |-> bitCnt + 8'($rose(cardPins.clk)) == CMD_BITS)
    else $error("command frame length wrong");
  start_bit_a: assert property ($fell(cardPins.cmdOutEnN) |-> !cardPins.cmdOut)
    else $error("start bit not low");
  tx_bit_a: assert property (!cardPins.cmdOutEnN && !$fell(cardPins.cmdOutEnN) && !$rose(cardPins.clk)
    && bitCnt == 8'h01 |-> cardPins.cmdOut)
    else $error("transmission bit not high");
  end_bit_a: assert property ($rose(cardPins.cmdOutEnN) |-> $past(cardPins.cmdOut))
    else $error("end bit not high");
  edge_only_a: assert property (!cardPins.cmdOutEnN && !$past(cardPins.cmdOutEnN)
    && $changed(cardPins.cmdOut) |-> $rose(cardPins.clk))
    else $error("command bit moved off a card edge");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  read_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  reset_idle_a: assert property (@(posedge sys_clk) disable iff (1'b0) sys_rst |=> !s_axi_rvalid && !s_axi_bvalid
    && cardPins.cmdOutEnN && cardPins.dataOutEnN && !cardPins.clk)
    else $error("outputs not idle in reset");
endmodule // card_bus_monitor

bind card_bus_host_controller card_bus_monitor mon (.*);

// File: verif/card_model.sv
module card_model (
  input logic                     sys_clk,
  input card_bus_pkg::card_pins_s pins,
  input logic [47:0]              resp,
  input logic                     respOn,
  output logic                    cmdLine,
  output logic                    dataLine,
  output logic [47:0]             got
);
  timeunit 1ns;
  timeprecision 1ns;
  import card_bus_pkg::*;
  logic       pc;
  logic       pcmd;
  logic       pen;
  logic [5:0] k = 6'h32;
  assign dataLine = 1'b1; // never busy, line rests at its pull-up
  initial cmdLine = 1'b1;
  // card edge seen a cycle late, with the levels from before it
  always @(posedge sys_clk) begin
    pc <= pins.clk;
    pcmd <= pins.cmdOut;
    pen <= pins.cmdOutEnN;
    if (pins.clk && !pc) begin
      if (!pen) begin
        got <= {got[46:0], pcmd};
        cmdLine <= 1'b1;
        k <= 6'h00;
      end else if (respOn && k < 6'h32) begin
        k <= k + 6'h01;
        cmdLine <= (k > 6'h01) ? resp[6'h31 - k] : 1'b1;
      end else cmdLine <= 1'b1;
    end
  end
endmodule // card_model

// File: verif/card_bus_host_controller_tb_top.sv
module card_bus_host_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import card_bus_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
  logic        cardCmdIn, cardDataIn, pc, pe, respOn = 1'b1;
  logic [47:0] resp = 48'h0, got;
  card_pins_s  cardPins;
  int          errCount = 0, nChecks = 0, cyc = 0, rises = 0, endMark = 0, lastRise = 0, per = 0;
  card_bus_host_controller uut (.*);
  card_model card (.sys_clk, .pins(cardPins), .resp, .respOn, .cmdLine(cardCmdIn), .dataLine(cardDataIn), .got);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pc <= cardPins.clk;
    pe <= cardPins.cmdOutEnN;
    if (cardPins.clk && !pc) begin
      rises <= rises + 1;
      lastRise <= cyc;
      per <= cyc - lastRise;
    end
    if (cardPins.cmdOutEnN && !pe) endMark <= rises + int'(cardPins.clk && !pc);
    if (cyc == 20000) begin
      errCount = errCount + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] a, input logic [31:0] on, input logic [31:0] off);
    wr(a, on);
    wr(a, off);
  endtask
  task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic re);
    wr(OFF_CMD_PORT, {26'h0, idx});
    for (int i = 3; i >= 0; i--) wr(OFF_CMD_PORT, {24'h0, arg[8*i +: 8]});
    pulse(OFF_CTL1, {30'h0, re, 1'b1}, {30'h0, re, 1'b0});
  endtask
  task automatic wait_flag(input int b);
    do rd(OFF_FLAGS); while (rv[b] !== 1'b1);
  endtask
  function automatic logic [47:0] tok(input logic t, input logic [5:0] idx, input logic [31:0] arg);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((({1'b0, t, idx, arg} >> i) & 1) ^ c[6] ? CRC7_POLY : 7'h00);
    return {1'b0, t, idx, arg, c, 1'b1};
  endfunction
  task automatic t_reset;
    rd(OFF_STATUS);
    chk(rv, 0);
    rd(OFF_CLK_DIV);
    chk(rv, DIV_RESET);
    rd(8'h40);
    chk(rr, RESP_SLVERR);
    wr(8'h22, 0);
    chk(br, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_clock;
    int r0;
    wr(OFF_CTL2, 1);
    wr(OFF_CLK_DIV, 0);
    send(6'h11, 32'h12345678, 0);
    r0 = rises;
    repeat (40) @(posedge sys_clk);
    chk(rises - r0, 0);
    rd(OFF_STATUS);
    chk(rv[0], 1);
    wr(OFF_CLK_DIV, 3);
    wait_flag(0);
    chk(got, tok(1, 6'h11, 32'h12345678));
    rd(OFF_STATUS);
    chk(rv[0], 0);
    repeat (100) @(posedge sys_clk);
    chk(rises - endMark, 8);
    chk(per, 6);
    $display("clock test done");
  endtask
  task automatic t_resp;
    wr(OFF_CLK_DIV, 1);
    wr(OFF_CMD_PORT, 8'h2a);
    wr(OFF_CMD_PORT, 8'h15);
    pulse(OFF_CTL0, 1, 0);
    resp = tok(0, 6'h27, 32'hcafe0123);
    send(6'h27, 32'h00c0ffee, 1);
    wait_flag(1);
    chk(got, tok(1, 6'h27, 32'h00c0ffee));
    rd(OFF_STATUS);
    chk(rv[2:1], 2'b11);
    for (int i = 5; i >= 0; i--) begin
      rd(OFF_CMD_PORT);
      chk(rv, resp[8*i +: 8]);
    end
    pulse(OFF_CTL0, 2, 0);
    rd(OFF_CMD_PORT);
    chk(rv, resp[47:40]);
    resp = tok(0, 6'h28, 32'h1) ^ 48'h2; // corrupt crc
    send(6'h28, 32'h1, 1);
    rd(OFF_STATUS);
    chk(rv[2:0], 3'b001);
    wait_flag(1);
    rd(OFF_STATUS);
    chk(rv[2:1], 2'b01);
    resp = {2'b00, 6'h3f, 32'h00ff8000, 7'h7f, 1'b1};
    wr(OFF_CTL0, 8);
    send(6'h01, 32'h0, 1);
    wait_flag(1);
    rd(OFF_STATUS);
    chk(rv[2:1], 2'b11);
    wr(OFF_CTL0, 0);
    $display("response test done");
  endtask
  task automatic t_path;
    respOn <= 1'b0;
    send(6'h05, 32'h0, 1);
    wait_flag(0);
    repeat (200) @(posedge sys_clk);
    pulse(OFF_CTL2, 3, 1);
    send(6'h06, 32'h0000beef, 0);
    wait_flag(0);
    chk(got, tok(1, 6'h06, 32'h0000beef));
    $display("path reset test done");
  endtask
  task automatic t_data;
    wr(OFF_CTL1, 8);
    wr(OFF_DATA_PORT, 8'ha5);
    pulse(OFF_CTL1, 12, 8);
    wait_flag(2);
    rd(OFF_STATUS);
    chk(rv[4:3], 2'b01);
    $display("data test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_clock();
    t_resp();
    t_path();
    t_data();
    complete_run();
  end
endmodule // card_bus_host_controller_tb_top
